// [rtl/acr_adc_ctrl.sv]
// Purpose: Control registers, result formatting, interrupt pacing and
//   DMA addressing for an on-chip analog converter.
// Assumes: Converter core and idle indication share clk.
// Notes: Read data appear the cycle after the read strobe.
`include "acr_consts.svh"

module acr_adc_ctrl #(
  parameter int DMA_AW = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Device state
  input wire logic cpu_idle,
  // Converter core
  output logic core_run,
  output logic core_12bit,
  output logic [2:0] core_channels,
  output logic core_sample,
  output logic [1:0] high_reference,
  output logic [1:0] low_reference,
  input wire logic core_sample_end,
  input wire logic core_done,
  input wire logic [11:0] core_data,
  input wire logic [1:0] core_channel,
  // Result and DMA
  output logic [15:0] result_word,
  output logic result_valid,
  output logic [DMA_AW-1:0] dma_addr,
  output logic dma_req,
  // Interrupt
  output logic irq
);

  generate
    if (DMA_AW < 6)
    begin : g_chk
      $error("DMA_AW too narrow for channel and slot");
    end
  endgenerate

  logic [15:0] ctrl1_r;
  logic [15:0] ctrl2_r;
  logic [1:0] istat_r;
  logic [1:0] imask_r;
  logic [3:0] dmacfg_r;
  logic [4:0] cnt_r;
  logic [3:0] ptr_r;
  logic [DMA_AW-1:0] slot_r;
  logic buffer_half_status_r;
  logic wr_c1;
  logic wr_c2;
  logic take;
  logic last;
  logic dma_en;
  logic [4:0] n_m1;
  logic rate_evt;
  logic dstep_evt;
  logic res12;
  logic [1:0] chg;
  logic [DMA_AW-1:0] sa_addr;
  logic [DMA_AW-1:0] sg_addr;
  logic [DMA_AW-1:0] sg_mask;
  logic [2:0] blog2;

  assign wr_c1 = reg_wr && reg_addr == `ACR_OFF_CTRL1;
  assign wr_c2 = reg_wr && reg_addr == `ACR_OFF_CTRL2;
  assign res12 = ctrl1_r[`ACR_C1_RES];
  assign dma_en = dmacfg_r[0];
  assign blog2 = dmacfg_r[3:1];
  assign chg = ctrl2_r[`ACR_C2_CHG_LO +: 2];

  // Core control
  assign core_run = ctrl1_r[`ACR_C1_ON]
    && !(ctrl1_r[`ACR_C1_SIDL] && cpu_idle);
  assign core_12bit = res12;
  assign core_sample = ctrl1_r[`ACR_C1_SAMPLE_ACTIVE];
  // Group code is forced to zero in 12-bit mode, so one channel there
  always_comb
  begin
    if (res12 || chg == 2'h0)
      core_channels = 3'h1;
    else if (chg[1])
      core_channels = 3'h4;
    else
      core_channels = 3'h2;
  end
  // No alternative reference exists in this build
  assign high_reference = `ACR_REF_SUPPLY;
  assign low_reference = `ACR_REF_GROUND;

  // Conversion pacing
  assign take = core_done && core_run;
  assign n_m1 = dma_en ? ctrl2_r[`ACR_C2_RATE_LO +: 5]
    : {1'b0, ctrl2_r[`ACR_C2_RATE_LO +: 4]};
  assign last = take && cnt_r == n_m1;
  assign rate_evt = last && !dma_en;
  assign dstep_evt = last && dma_en;

  always_ff @(posedge clk)
  begin
    if (reset || !ctrl1_r[`ACR_C1_ON])
      cnt_r <= 5'h00;
    else if (last)
      cnt_r <= 5'h00;
    else if (take)
      cnt_r <= cnt_r + 5'h01;
  end

  // Stand-alone buffer pointer and half tracking
  always_ff @(posedge clk)
  begin
    if (reset || !ctrl1_r[`ACR_C1_ON])
      ptr_r <= 4'h0;
    else if (last)
      ptr_r <= 4'h0;
    else if (take)
      ptr_r <= ptr_r + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset || !ctrl2_r[`ACR_C2_SPLIT])
      buffer_half_status_r <= 1'b0;
    else if (rate_evt || dstep_evt)
      buffer_half_status_r <= !buffer_half_status_r;
  end

  always_ff @(posedge clk)
  begin
    if (reset || !dma_en)
      slot_r <= '0;
    else if (dstep_evt)
      slot_r <= slot_r + 1'b1;
  end

  // Split mode keeps each half in its own upper address bit
  assign sa_addr = ctrl2_r[`ACR_C2_SPLIT]
    ? DMA_AW'({buffer_half_status_r, ptr_r[2:0]}) : DMA_AW'(ptr_r);
  assign sg_mask = DMA_AW'((1 << blog2) - 1);
  assign sg_addr = (DMA_AW'(res12 ? 2'h0 : core_channel) << blog2)
    | (slot_r & sg_mask);

  // Result formatting
  function automatic acr_pkg::acr_word_t fmt_word(
    input logic [11:0] d,
    input logic r12,
    input acr_pkg::acr_fmt_e f
  );
    acr_pkg::acr_word_t w;
    w = 16'h0000;
    if (r12)
    begin
      unique case (f)
        acr_pkg::ACR_FMT_SFRAC: w = {~d[11], d[10:0], 4'h0};
        acr_pkg::ACR_FMT_FRAC: w = {d, 4'h0};
        acr_pkg::ACR_FMT_SINT: w = {{5{~d[11]}}, d[10:0]};
        acr_pkg::ACR_FMT_INT: w = {4'h0, d};
      endcase
    end
    else
    begin
      unique case (f)
        acr_pkg::ACR_FMT_SFRAC: w = {~d[9], d[8:0], 6'h00};
        acr_pkg::ACR_FMT_FRAC: w = {d[9:0], 6'h00};
        acr_pkg::ACR_FMT_SINT: w = {{7{~d[9]}}, d[8:0]};
        acr_pkg::ACR_FMT_INT: w = {6'h00, d[9:0]};
      endcase
    end
    return w;
  endfunction : fmt_word

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      result_word <= `ACR_RST_CTRL;
      result_valid <= 1'b0;
      dma_addr <= '0;
      dma_req <= 1'b0;
    end
    else
    begin
      result_valid <= take;
      dma_req <= take && dma_en;
      if (take)
      begin
        result_word <= fmt_word(core_data, res12,
          acr_pkg::acr_fmt_e'(ctrl1_r[`ACR_C1_FMT_LO +: 2]));
        dma_addr <= ctrl1_r[`ACR_C1_BUILD] ? sa_addr
          : sg_addr;
      end
    end
  end

  // Control one
  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl1_r <= `ACR_RST_CTRL;
    else
    begin
      if (wr_c1)
        ctrl1_r <= reg_wdata & `ACR_C1_WMASK;
      // Hardware updates win over a software write in the same cycle
      if (core_sample_end)
        ctrl1_r[`ACR_C1_SAMPLE_ACTIVE] <= 1'b0;
      if (take)
        ctrl1_r[`ACR_C1_DONE] <= 1'b1;
    end
  end

  // Control two; status bit is live, not stored
  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl2_r <= `ACR_RST_CTRL;
    else if (wr_c2)
    begin
      ctrl2_r <= reg_wdata & `ACR_C2_WMASK;
      if (res12)
        ctrl2_r[`ACR_C2_CHG_LO +: 2] <= 2'h0;
    end
    else if (res12)
      ctrl2_r[`ACR_C2_CHG_LO +: 2] <= 2'h0;
  end

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge clk)
  begin
    if (reset)
      istat_r <= `ACR_RST_IRQ;
    else
    begin
      if (reg_wr && reg_addr == `ACR_OFF_ISTAT)
        istat_r <= istat_r & ~reg_wdata[1:0];
      if (rate_evt)
        istat_r[`ACR_IS_RATE] <= 1'b1;
      if (dstep_evt)
        istat_r[`ACR_IS_DSTEP] <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      imask_r <= `ACR_RST_IRQ;
    else if (reg_wr && reg_addr == `ACR_OFF_IMASK)
      imask_r <= reg_wdata[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      dmacfg_r <= `ACR_RST_DMACFG;
    else if (reg_wr && reg_addr == `ACR_OFF_DMACFG)
      dmacfg_r <= reg_wdata[3:0];
  end

  assign irq = |(istat_r & imask_r);

  // Read port, unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `ACR_OFF_CTRL1: reg_rdata <= ctrl1_r;
        `ACR_OFF_CTRL2: reg_rdata <= {ctrl2_r[15:8], buffer_half_status_r,
          ctrl2_r[6:0]};
        `ACR_OFF_RESULT: reg_rdata <= result_word;
        `ACR_OFF_ISTAT: reg_rdata <= {14'h0000, istat_r};
        `ACR_OFF_IMASK: reg_rdata <= {14'h0000, imask_r};
        `ACR_OFF_DMACFG: reg_rdata <= {12'h000, dmacfg_r};
        `ACR_OFF_DMAADDR: reg_rdata <= 16'(dma_addr);
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // Checks
  sequence s_rd_c1;
    reg_rd && reg_addr == `ACR_OFF_CTRL1;
  endsequence

  sequence s_rd_c2_12;
    reg_rd && reg_addr == `ACR_OFF_CTRL2 && res12;
  endsequence

  sequence s_take10_int;
    take && !res12 && ctrl1_r[9:8] == 2'h0;
  endsequence

  sequence s_take12_sint;
    take && res12 && ctrl1_r[9:8] == 2'h1;
  endsequence

  a_run_gate: assert property (@(posedge clk) disable iff (reset)
    !ctrl1_r[`ACR_C1_ON] |-> !core_run)
    else $error("converter runs while off");

  a_idle_stop: assert property (@(posedge clk) disable iff (reset)
    ctrl1_r[`ACR_C1_ON] && cpu_idle |-> core_run == !ctrl1_r[`ACR_C1_SIDL])
    else $error("idle stop gating wrong");

  a_fmt_int10: assert property (@(posedge clk) disable iff (reset)
    s_take10_int |=> result_word == {6'h00, $past(core_data[9:0])})
    else $error("10-bit integer format wrong");

  a_fmt_sint12: assert property (@(posedge clk) disable iff (reset)
    s_take12_sint |=> result_word == {{5{~$past(core_data[11])}},
      $past(core_data[10:0])})
    else $error("12-bit signed integer format wrong");

  a_ref_fixed: assert property (@(posedge clk) disable iff (reset)
    high_reference == `ACR_REF_SUPPLY && low_reference == `ACR_REF_GROUND)
    else $error("reference routing changed");

  a_group_zero: assert property (@(posedge clk) disable iff (reset)
    s_rd_c2_12 ##1 res12 |-> reg_rdata[9:8] == 2'h0)
    else $error("channel group visible in 12-bit mode");

  a_unimpl_zero: assert property (@(posedge clk) disable iff (reset)
    s_rd_c1 |=> reg_rdata[14] == 1'b0 && reg_rdata[11] == 1'b0)
    else $error("unimplemented bit reads one");

  a_rate_every: assert property (@(posedge clk) disable iff (reset)
    take && !dma_en && ctrl2_r[5:2] == 4'h0 |=> istat_r[`ACR_IS_RATE])
    else $error("interrupt missing at rate one");

  a_dma_step: assert property (@(posedge clk) disable iff (reset)
    dstep_evt && !reg_wr |=> slot_r == $past(slot_r) + 1'b1)
    else $error("DMA slot did not step");

  a_done_set: assert property (@(posedge clk) disable iff (reset)
    take |=> ctrl1_r[`ACR_C1_DONE] ##1 result_valid == 1'b0 || take)
    else $error("done flag not set");

  a_half_flip: assert property (@(posedge clk) disable iff (reset)
    ctrl2_r[`ACR_C2_SPLIT] && rate_evt && !wr_c2 |=> buffer_half_status_r != $past(buffer_half_status_r))
    else $error("buffer half not toggled");

  a_chan_four: assert property (@(posedge clk) disable iff (reset)
    !res12 && chg[1] |-> core_channels == 3'h4)
    else $error("group code 1x not four channels");

endmodule : acr_adc_ctrl

// [rtl/acr_consts.svh]
// Purpose: Offsets, bit positions, masks and reset values of the
//   converter control block.
// Assumes: Word-indexed register port, 16-bit data.
// Notes: Definitions only.
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// Register offsets
`define ACR_OFF_CTRL1 4'h0
`define ACR_OFF_CTRL2 4'h1
`define ACR_OFF_RESULT 4'h2
`define ACR_OFF_ISTAT 4'h3
`define ACR_OFF_IMASK 4'h4
`define ACR_OFF_DMACFG 4'h5
`define ACR_OFF_DMAADDR 4'h6

// Control one fields
`define ACR_C1_ON 15
`define ACR_C1_SIDL 13
`define ACR_C1_BUILD 12
`define ACR_C1_RES 10
`define ACR_C1_FMT_LO 8
`define ACR_C1_SAMPLE_ACTIVE 1
`define ACR_C1_DONE 0
`define ACR_C1_WMASK 16'hB7FF

// Control two fields
`define ACR_C2_CHG_LO 8
`define ACR_C2_BUFFER_HALF_STATUS 7
`define ACR_C2_RATE_LO 2
`define ACR_C2_SPLIT 1
`define ACR_C2_WMASK 16'hE77F

// Interrupt status bits
`define ACR_IS_RATE 0
`define ACR_IS_DSTEP 1

// Reset values
`define ACR_RST_CTRL 16'h0000
`define ACR_RST_IRQ 2'h0
`define ACR_RST_DMACFG 4'h0

// Fixed reference routing codes
`define ACR_REF_SUPPLY 2'h1
`define ACR_REF_GROUND 2'h2

`endif

// [rtl/acr_pkg.sv]
// Purpose: Types shared by the converter control block.
// Assumes: Nothing beyond the constants header.
// Notes: Enum order follows the format field encoding.
package acr_pkg;

  typedef enum logic [1:0] {
    ACR_FMT_INT,
    ACR_FMT_SINT,
    ACR_FMT_FRAC,
    ACR_FMT_SFRAC
  } acr_fmt_e;

  typedef logic [15:0] acr_word_t;

endpackage : acr_pkg

// [verif/acr_adc_ctrl_tb.sv]
// Purpose: Self-checking bench for the converter control block.
// Assumes: Core model answers one or two cycles after go.
// Notes: One gap cycle between register accesses keeps strobes clean.
`include "acr_consts.svh"
module acr_adc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic cpu_idle = 1'b0, go = 1'b0, slow = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, result_word;
  logic [11:0] word = 12'h000, core_data;
  logic [1:0] chan = 2'h0;
  logic [1:0] core_channel, high_reference, low_reference;
  logic [2:0] core_channels;
  logic [7:0] dma_addr;
  logic core_run, core_12bit, core_sample, core_sample_end, core_done;
  logic result_valid, dma_req, irq;
  int mismatches = 0, n_tests = 0;
  always #5 clk = ~clk;
  acr_adc_ctrl #(.DMA_AW(8)) i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_idle(cpu_idle), .core_run(core_run), .core_12bit(core_12bit),
    .core_channels(core_channels), .core_sample(core_sample),
    .high_reference(high_reference), .low_reference(low_reference),
    .core_sample_end(core_sample_end), .core_done(core_done), .core_data(core_data),
    .core_channel(core_channel), .result_word(result_word), .result_valid(result_valid),
    .dma_addr(dma_addr), .dma_req(dma_req), .irq(irq));
  acr_core_model i_core (.clk(clk), .core_run(core_run), .go(go), .slow(slow), .word(word),
    .chan(chan),
    .core_sample_end(core_sample_end), .core_done(core_done), .core_data(core_data),
    .core_channel(core_channel));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (e !== g)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask : rchk
  task automatic conv(input logic [11:0] d);
    @(posedge clk);
    word <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 6 && result_valid !== 1'b1; i++)
      @(posedge clk) #1;
    chk("valid", 16'h0001, {15'h0000, result_valid});
  endtask : conv
  function automatic logic [15:0] fexp(input logic [2:0] m, input logic [11:0] d);
    logic [9:0] t;
    t = d[9:0];
    case (m)
      3'h7: fexp = {~d[11], d[10:0], 4'h0};
      3'h6: fexp = {d, 4'h0};
      3'h5: fexp = {{5{~d[11]}}, d[10:0]};
      3'h4: fexp = {4'h0, d};
      3'h3: fexp = {~t[9], t[8:0], 6'h00};
      3'h2: fexp = {t, 6'h00};
      3'h1: fexp = {{7{~t[9]}}, t[8:0]};
      default: fexp = {6'h00, t};
    endcase
  endfunction : fexp
  task automatic t_regs;
    rchk(`ACR_OFF_CTRL1, 16'h0000, "ctrl1");
    chk("refs", {12'h000, `ACR_REF_SUPPLY, `ACR_REF_GROUND}, {12'h000, high_reference,
      low_reference});
    wr(`ACR_OFF_CTRL2, 16'h0200);
    chk("chans", 16'h0004, {13'h0000, core_channels});
    wr(`ACR_OFF_CTRL2, 16'h0100);
    chk("chans", 16'h0002, {13'h0000, core_channels});
    wr(`ACR_OFF_CTRL1, 16'hFFFF);
    wr(`ACR_OFF_CTRL2, 16'hFFFF);
    rchk(`ACR_OFF_CTRL1, 16'hB7FF, "ctrl1");
    rchk(`ACR_OFF_CTRL2, 16'hE47F, "ctrl2");
    chk("chans", 16'h0001, {13'h0000, core_channels});
    chk("refs", 16'h0006, {12'h000, high_reference, low_reference});
    rchk(4'hF, 16'h0000, "unmapped");
    wr(`ACR_OFF_CTRL2, 16'h0000);
  endtask : t_regs
  task automatic t_run;
    wr(`ACR_OFF_CTRL1, 16'h0000);
    chk("run", 16'h0000, {15'h0000, core_run});
    @(posedge clk);
    cpu_idle <= 1'b1;
    wr(`ACR_OFF_CTRL1, 16'hA000);
    chk("run", 16'h0000, {15'h0000, core_run});
    wr(`ACR_OFF_CTRL1, 16'h8000);
    chk("run", 16'h0001, {15'h0000, core_run});
    @(posedge clk);
    cpu_idle <= 1'b0;
  endtask : t_run
  task automatic t_fmt;
    logic [15:0] c;
    logic [11:0] d;
    for (int i = 0; i < 8; i++)
    begin
      d = i[0] ? 12'hA5C : 12'h5A3;
      c = {5'h10, i[2], i[1:0], 8'h02};
      slow <= i[0];
      wr(`ACR_OFF_CTRL1, c);
      chk("res", {15'h0000, i[2]}, {15'h0000, core_12bit});
      chk("sample_active", 16'h0001, {15'h0000, core_sample});
      conv(d);
      chk("word", fexp(i[2:0], d), result_word);
      // Slow core ends sampling, so the sample bit must be gone there
      rchk(`ACR_OFF_CTRL1, i[0] ? ((c & 16'hFFFD) | 16'h0001) : (c | 16'h0001),
        "flags");
    end
    slow <= 1'b0;
  endtask : t_fmt
  task automatic t_rate(input logic [15:0] cfg, input logic [15:0] r, input int b, input int n);
    wr(`ACR_OFF_CTRL1, 16'h0000);
    wr(`ACR_OFF_DMACFG, cfg);
    wr(`ACR_OFF_CTRL2, r << 2);
    wr(`ACR_OFF_IMASK, 16'h0001 << b);
    wr(`ACR_OFF_ISTAT, 16'h0003);
    wr(`ACR_OFF_CTRL1, 16'h8000);
    for (int k = 1; k <= n; k++)
    begin
      conv(12'h123);
      chk("dreq", {15'h0000, cfg[0]}, {15'h0000, dma_req});
      chk("irq", {15'h0000, k == n}, {15'h0000, irq});
    end
    // Masking must hide a pending event without losing it
    wr(`ACR_OFF_IMASK, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(`ACR_OFF_IMASK, 16'h0001 << b);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(`ACR_OFF_ISTAT, 16'h0001 << b);
    chk("irq", 16'h0000, {15'h0000, irq});
  endtask : t_rate
  task automatic t_dma;
    wr(`ACR_OFF_CTRL1, 16'h0000);
    wr(`ACR_OFF_DMACFG, 16'h0000);
    wr(`ACR_OFF_DMACFG, 16'h0005);
    wr(`ACR_OFF_CTRL2, 16'h0000);
    wr(`ACR_OFF_CTRL1, 16'h8000);
    @(posedge clk);
    chan <= 2'h2;
    conv(12'h123);
    chk("sgaddr", 16'h0008, {8'h00, dma_addr});
    conv(12'h123);
    chk("sgaddr", 16'h0009, {8'h00, dma_addr});
    wr(`ACR_OFF_CTRL1, 16'h0000);
    wr(`ACR_OFF_DMACFG, 16'h0000);
    wr(`ACR_OFF_CTRL2, 16'h0006);
    wr(`ACR_OFF_CTRL1, 16'h9000);
    conv(12'h123);
    chk("baddr", 16'h0000, {8'h00, dma_addr});
    rchk(`ACR_OFF_CTRL2, 16'h0006, "half");
    conv(12'h123);
    chk("baddr", 16'h0001, {8'h00, dma_addr});
    rchk(`ACR_OFF_CTRL2, 16'h0086, "half");
    conv(12'h123);
    chk("baddr", 16'h0008, {8'h00, dma_addr});
    rchk(`ACR_OFF_DMAADDR, 16'h0008, "daddr");
    rchk(`ACR_OFF_RESULT, 16'h0123, "result");
  endtask : t_dma
  task automatic tally_and_finish;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_run();
    t_fmt();
    t_rate(16'h0000, 16'h0011, 0, 2);
    t_rate(16'h0000, 16'h000F, 0, 16);
    t_rate(16'h0001, 16'h0011, 1, 18);
    t_dma();
    tally_and_finish();
  end
endmodule : acr_adc_ctrl_tb

// [verif/acr_core_model.sv]
// Purpose: Behavioural converter core facing the control block.
// Assumes: Bench raises go for one cycle per conversion.
// Notes: Slow mode answers a cycle later and ends sampling first.
module acr_core_model (
  // Clock
  input wire logic clk,
  // Bench and block control
  input wire logic core_run,
  input wire logic go,
  input wire logic slow,
  input wire logic [11:0] word,
  input wire logic [1:0] chan,
  // Toward block
  output logic core_sample_end,
  output logic core_done,
  output logic [11:0] core_data,
  output logic [1:0] core_channel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go_d_r = 1'b0;
  logic fire;
  initial
  begin
    core_sample_end = 1'b0;
    core_done = 1'b0;
    core_data = 12'h000;
    core_channel = 2'h0;
  end
  assign fire = slow ? go_d_r : go;
  // A switched-off core never finishes a conversion
  always @(posedge clk)
  begin
    go_d_r <= go;
    core_sample_end <= slow & go;
    core_done <= fire & core_run;
    // Data outside a result toggles, so a stale sample never matches
    core_data <= fire ? word : ~core_data;
    core_channel <= fire ? chan : ~core_channel;
  end
endmodule : acr_core_model
